// ==== rtl/tasf_defs.svh ====
// constants of the three axis sample buffer: register map, field layout and mode codes
// assumes it is included by bare name in the package and in the design modules
`ifndef TASF_DEFS_SVH
`define TASF_DEFS_SVH

// ---------------------------------------------------------------
// register sub-addresses (low seven bits of the sub-address)
// ---------------------------------------------------------------
`define TASF_ADDR_X_LOW 7'h28
`define TASF_ADDR_X_HIGH 7'h29
`define TASF_ADDR_Y_LOW 7'h2a
`define TASF_ADDR_Y_HIGH 7'h2b
`define TASF_ADDR_Z_LOW 7'h2c
`define TASF_ADDR_Z_HIGH 7'h2d
`define TASF_ADDR_CTRL 7'h30
`define TASF_ADDR_SRC 7'h31
`define TASF_ADDR_PINCFG 7'h32

// ---------------------------------------------------------------
// sub-address and field layout
// ---------------------------------------------------------------
`define TASF_SUB_INC_BIT 7
`define TASF_MODE_HI 7
`define TASF_MODE_LO 5
`define TASF_WTM_HI 4
`define TASF_WTM_LO 0
`define TASF_SRC_WTM_BIT 7
`define TASF_SRC_FULL_BIT 6
`define TASF_SRC_EMPTY_BIT 5
`define TASF_CFG_WTM_BIT 2
`define TASF_CFG_FULL_BIT 1
`define TASF_CFG_EMPTY_BIT 0

// ---------------------------------------------------------------
// reset values, mode codes and sizes
// ---------------------------------------------------------------
`define TASF_CTRL_RESET 8'h00
`define TASF_PINCFG_RESET 3'h0
`define TASF_MODE_BYPASS 3'h0
`define TASF_MODE_FIFO 3'h1
`define TASF_MODE_STREAM 3'h2
`define TASF_MODE_TRIGGER 3'h3
`define TASF_DEPTH 32
`define TASF_PTR_W 5
`define TASF_LVL_W 6
`define TASF_LVL_FULL 6'h20
`define TASF_CHANNELS 3

`endif

// ==== rtl/tasf_pkg.sv ====
// types shared by the three axis sample buffer modules
// assumes tasf_defs.svh is on the include path
`include "tasf_defs.svh"

package tasf_pkg;
    // buffer mode field as held in the control register
    typedef logic [2:0] tasf_mode_t;
    // one rate sample of one axis
    typedef logic [15:0] tasf_sample_t;
    // fill level of one channel buffer, 0 to 32
    typedef logic [5:0] tasf_level_t;
    // register sub-address without the increment bit
    typedef logic [6:0] tasf_addr_t;
endpackage : tasf_pkg

// ==== rtl/tasf_ring.sv ====
// one channel ring buffer of 32 samples with a fill counter
// assumes the caller never asks for push and clear together to mean anything but clear
`timescale 1ns/1ns
`default_nettype none
`include "tasf_defs.svh"

module tasf_ring (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // control
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic overwrite_i,
    input wire logic pop_i,
    // data
    input wire tasf_pkg::tasf_sample_t wdata_i,
    output tasf_pkg::tasf_sample_t head_o,
    // state
    output tasf_pkg::tasf_level_t level_o,
    output logic empty_o,
    output logic full_o
);
    import tasf_pkg::*;

    // ---------------------------------------------------------------
    // storage and pointers
    // ---------------------------------------------------------------
    tasf_sample_t mem [`TASF_DEPTH]; // sample slots
    logic [`TASF_PTR_W-1:0] wr_ptr; // next slot to write
    logic [`TASF_PTR_W-1:0] rd_ptr; // oldest stored slot
    tasf_level_t count; // fill counter
    logic pop_ok; // a pop that really removes
    logic push_ok; // a push that lands in memory
    logic drop_old; // stream overwrite of the oldest entry

    assign empty_o = (count == '0);
    assign full_o = (count == `TASF_LVL_FULL);
    assign level_o = count;
    assign head_o = mem[rd_ptr];
    assign pop_ok = pop_i && !empty_o;
    // a full buffer still takes a sample if a pop frees a slot or overwrite is allowed
    assign push_ok = push_i && (!full_o || pop_ok || overwrite_i);
    assign drop_old = push_i && full_o && !pop_ok && overwrite_i;

    // ---------------------------------------------------------------
    // memory write
    // ---------------------------------------------------------------
    // no reset on the array so it can map to plain storage
    always_ff @(posedge mclk_i) begin
        if (push_ok && !clear_i) begin
            mem[wr_ptr] <= wdata_i;
        end
    end

    // ---------------------------------------------------------------
    // pointers and counter
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clear_i) begin
            // emptied whenever bypass is selected
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop_ok || drop_old) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push_ok && !drop_old && !pop_ok) begin
                count <= count + 1'b1;
            end else if (pop_ok && !push_ok) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : tasf_ring

`default_nettype wire

// ==== rtl/tasf_buffer.sv ====
// three axis sample buffer: modes, watermark, status, output registers and register access
// assumes samples arrive as a one-cycle strobe on mclk_i and the register port is on mclk_i
`timescale 1ns/1ns
`default_nettype none
`include "tasf_defs.svh"

// Summary of operation
// - three separate 32-sample 16-bit channel buffers
// - four modes chosen by buffer mode field
// - watermark level is control bits 4 to 0
// - watermark, empty, full each gate irq pin
// - bypass keeps buffer empty, live overwrite
// - fifo stores samples, watermark at level
// - fifo stops accepting when 32 filled
// - writing bypass restarts collection after full
// - stream drops oldest when full, same watermark
// - buffered modes return stored data on reads
// - x high read, or x low read without increment, loads and removes oldest
// - burst wraps from z high to x low
// - sub-address msb selects address auto-increment
module tasf_buffer (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // rate samples from the sensing chain
    input wire logic sample_valid_i,
    input wire tasf_pkg::tasf_sample_t sample_x_i,
    input wire tasf_pkg::tasf_sample_t sample_y_i,
    input wire tasf_pkg::tasf_sample_t sample_z_i,
    // register access from the serial front end
    input wire logic reg_sel_i,
    input wire logic [7:0] reg_sub_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // interrupt pin
    output logic ready_irq2_pin_o
);
    import tasf_pkg::*;

    // ---------------------------------------------------------------
    // registers and state
    // ---------------------------------------------------------------
    tasf_mode_t buffer_mode; // buffer_mode_field
    logic [4:0] watermark_level; // threshold on fill level
    logic [2:0] interrupt_pin_config; // per-event irq enables
    tasf_addr_t addr_ptr; // current register address
    logic auto_inc; // increment after each access
    tasf_sample_t rate_x; // axis output registers
    tasf_sample_t rate_y;
    tasf_sample_t rate_z;
    tasf_sample_t head [`TASF_CHANNELS]; // oldest entry per channel
    tasf_sample_t wdata [`TASF_CHANNELS]; // incoming sample per channel
    tasf_level_t level [`TASF_CHANNELS]; // fill level per channel
    logic empty [`TASF_CHANNELS];
    logic full [`TASF_CHANNELS];
    logic buffered; // fifo, stream or trigger
    logic overwrite; // stream or trigger
    logic clear; // bypass holds buffers empty
    logic push; // sample offered to buffers
    logic pop; // register read that drains one entry
    logic wtm_flag; // fill level reached the watermark
    logic [7:0] src_value; // buffer_source_register contents
    logic [7:0] next_rdata; // read mux output

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    // codes other than fifo, stream and trigger behave as bypass
    assign buffered = (buffer_mode == `TASF_MODE_FIFO) || overwrite;
    assign overwrite = (buffer_mode == `TASF_MODE_STREAM) || (buffer_mode == `TASF_MODE_TRIGGER);
    assign clear = !buffered;
    assign push = sample_valid_i && buffered;

    // a read of x high, or a non-incrementing read of x low, drains one entry
    assign pop = reg_rd_i && buffered &&
                 ((addr_ptr == `TASF_ADDR_X_HIGH) || ((addr_ptr == `TASF_ADDR_X_LOW) && !auto_inc));

    assign wdata[0] = sample_x_i;
    assign wdata[1] = sample_y_i;
    assign wdata[2] = sample_z_i;

    // ---------------------------------------------------------------
    // channel buffers
    // ---------------------------------------------------------------
    // all channels share strobes, so their levels stay equal
    for (genvar ch = 0; ch < `TASF_CHANNELS; ch++) begin : g_chan
        tasf_ring u_ring (
            .mclk_i(mclk_i),
            .arst_n_i(arst_n_i),
            .clear_i(clear),
            .push_i(push),
            .overwrite_i(overwrite),
            .pop_i(pop),
            .wdata_i(wdata[ch]),
            .head_o(head[ch]),
            .level_o(level[ch]),
            .empty_o(empty[ch]),
            .full_o(full[ch])
        );
    end

    // ---------------------------------------------------------------
    // status and interrupt
    // ---------------------------------------------------------------
    assign wtm_flag = buffered && (level[0] >= {1'b0, watermark_level});
    always_comb begin
        src_value = 8'h00;
        src_value[`TASF_SRC_WTM_BIT] = wtm_flag;
        src_value[`TASF_SRC_FULL_BIT] = full[0];
        src_value[`TASF_SRC_EMPTY_BIT] = empty[0];
        // level 32 reads as 0 here; the full bit tells it apart
        src_value[4:0] = level[0][4:0];
    end

    // irq pin follows the enabled conditions as levels
    assign ready_irq2_pin_o = (interrupt_pin_config[`TASF_CFG_WTM_BIT] && wtm_flag) ||
                              (interrupt_pin_config[`TASF_CFG_FULL_BIT] && full[0]) ||
                              (interrupt_pin_config[`TASF_CFG_EMPTY_BIT] && empty[0]);

    // ---------------------------------------------------------------
    // control register writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            buffer_mode <= 3'(`TASF_CTRL_RESET >> `TASF_MODE_LO);
            // low five bits of the control reset value
            watermark_level <= 5'(`TASF_CTRL_RESET);
            interrupt_pin_config <= `TASF_PINCFG_RESET;
        end else if (reg_wr_i) begin
            if (addr_ptr == `TASF_ADDR_CTRL) begin
                buffer_mode <= reg_wdata_i[`TASF_MODE_HI:`TASF_MODE_LO];
                watermark_level <= reg_wdata_i[`TASF_WTM_HI:`TASF_WTM_LO];
            end
            if (addr_ptr == `TASF_ADDR_PINCFG) begin
                interrupt_pin_config <= reg_wdata_i[2:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // address pointer
    // ---------------------------------------------------------------
    // a burst walking past z high goes back to x low so the host can loop
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_ptr <= 7'h00;
            auto_inc <= 1'b0;
        end else if (reg_sel_i) begin
            addr_ptr <= reg_sub_i[6:0];
            auto_inc <= reg_sub_i[`TASF_SUB_INC_BIT];
        end else if ((reg_rd_i || reg_wr_i) && auto_inc) begin
            if (addr_ptr == `TASF_ADDR_Z_HIGH) begin
                addr_ptr <= `TASF_ADDR_X_LOW;
            end else begin
                addr_ptr <= addr_ptr + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // axis output registers
    // ---------------------------------------------------------------
    // bypass shows the live sample; buffered modes only change on a drain
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rate_x <= 16'h0000;
            rate_y <= 16'h0000;
            rate_z <= 16'h0000;
        end else if (!buffered && sample_valid_i) begin
            rate_x <= sample_x_i;
            rate_y <= sample_y_i;
            rate_z <= sample_z_i;
        end else if (pop && !empty[0]) begin
            rate_x <= head[0];
            rate_y <= head[1];
            rate_z <= head[2];
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_comb begin
        case (addr_ptr)
            `TASF_ADDR_X_LOW: next_rdata = rate_x[7:0];
            `TASF_ADDR_X_HIGH: next_rdata = rate_x[15:8];
            `TASF_ADDR_Y_LOW: next_rdata = rate_y[7:0];
            `TASF_ADDR_Y_HIGH: next_rdata = rate_y[15:8];
            `TASF_ADDR_Z_LOW: next_rdata = rate_z[7:0];
            `TASF_ADDR_Z_HIGH: next_rdata = rate_z[15:8];
            `TASF_ADDR_CTRL: next_rdata = {buffer_mode, watermark_level};
            `TASF_ADDR_SRC: next_rdata = src_value;
            `TASF_ADDR_PINCFG: next_rdata = {5'h00, interrupt_pin_config};
            // unmapped addresses read as zero
            default: next_rdata = 8'h00;
        endcase
    end

    // the byte leaves before the output register is reloaded by the same read
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_full_sample;
        full[0] && sample_valid_i && !pop;
    endsequence

    sequence s_ctrl_write;
        reg_wr_i && !reg_sel_i && (addr_ptr == `TASF_ADDR_CTRL);
    endsequence

    // an incrementing read that is not the start of a new transaction
    sequence s_burst_read;
        reg_rd_i && !reg_sel_i && auto_inc;
    endsequence

    a_bypass_empty: assert property (clear |=> empty[0] && empty[1] && empty[2])
        else $error("buffer not empty in bypass");

    a_fifo_stop: assert property ((buffer_mode == `TASF_MODE_FIFO) and s_full_sample
        |=> full[0] && $stable(rate_x))
        else $error("fifo accepted sample while full");

    a_stream_full: assert property (overwrite and s_full_sample |=> full[0] && (level[0] == `TASF_LVL_FULL))
        else $error("stream lost fill level on overwrite");

    // ---------------------------------------------------------------
    // register pointer checks
    // ---------------------------------------------------------------
    a_burst_wrap: assert property (s_burst_read and (addr_ptr == `TASF_ADDR_Z_HIGH)
        |=> addr_ptr == `TASF_ADDR_X_LOW)
        else $error("burst did not wrap to x low");

    // away from the wrap point the pointer steps by exactly one
    a_burst_step: assert property (s_burst_read and (addr_ptr != `TASF_ADDR_Z_HIGH)
        |=> addr_ptr == $past(addr_ptr) + 7'h01)
        else $error("burst pointer did not step");

    // a transaction start loads both the address and the increment bit
    a_sel_load: assert property (reg_sel_i
        |=> (addr_ptr == $past(reg_sub_i[6:0])) && (auto_inc == $past(reg_sub_i[`TASF_SUB_INC_BIT])))
        else $error("sub-address not loaded");

    // every read is answered one cycle later with the byte at the pointer
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o && (reg_rdata_o == $past(next_rdata)))
        else $error("read not answered");

    // ---------------------------------------------------------------
    // drain, fill and interrupt checks
    // ---------------------------------------------------------------
    a_pop_load: assert property (pop && !empty[0] && !sample_valid_i
        |=> (rate_x == $past(head[0])) && (rate_z == $past(head[2])) && (level[0] == $past(level[0]) - 6'h01))
        else $error("drain did not load oldest entry");

    a_irq_wtm: assert property (interrupt_pin_config[`TASF_CFG_WTM_BIT] && buffered
        && (level[0] >= {1'b0, watermark_level}) |-> ready_irq2_pin_o)
        else $error("watermark irq missing");

    // each enabled event on its own must raise the pin
    a_irq_full: assert property (interrupt_pin_config[`TASF_CFG_FULL_BIT] && full[0] |-> ready_irq2_pin_o)
        else $error("full irq missing");

    a_irq_empty: assert property (interrupt_pin_config[`TASF_CFG_EMPTY_BIT] && empty[0] |-> ready_irq2_pin_o)
        else $error("empty irq missing");

    a_fill_count: assert property ((buffer_mode == `TASF_MODE_FIFO) && sample_valid_i && !full[0] && !pop
        ##1 (buffer_mode == `TASF_MODE_FIFO) |-> level[0] == $past(level[0]) + 6'h01)
        else $error("fill level did not count up");

    // the counter never passes the depth, whatever the mode
    a_level_cap: assert property (level[0] <= `TASF_LVL_FULL)
        else $error("fill level above depth");

    // status is taken from channel 0, which only holds while all move together
    a_chan_equal: assert property ((level[0] == level[1]) && (level[1] == level[2]))
        else $error("channel levels differ");

    a_ctrl_write: assert property (s_ctrl_write |=> (buffer_mode == $past(reg_wdata_i[7:5]))
        && (watermark_level == $past(reg_wdata_i[4:0])))
        else $error("control write not taken");

    a_bypass_live: assert property (clear && sample_valid_i |=> rate_y == $past(sample_y_i))
        else $error("bypass output not live");

    // the clear lands one edge after the mode register changes
    a_restart: assert property (s_ctrl_write and (reg_wdata_i[7:5] == `TASF_MODE_BYPASS)
        |=> ##1 empty[0] && !full[0])
        else $error("bypass write did not restart");
endmodule : tasf_buffer

`default_nettype wire

// ==== tb/tasf_host.sv ====
// host model: the processor that reaches the sample buffer through its register port
// assumes the port is sampled on the rising edge of mclk_i, one byte per rd or wr pulse
`timescale 1ns/1ns
`default_nettype none

module tasf_host (
    // clock
    input wire logic mclk_i,
    // register port toward the buffer
    output logic reg_sel_o,
    output logic [7:0] reg_sub_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // ---------------------------------------------------------------
    // idle levels
    // ---------------------------------------------------------------
    initial begin
        reg_sel_o = 1'b0;
        reg_sub_o = 8'h00;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // open a transaction; bit 7 asks for auto-increment
    task automatic sel(input logic [7:0] sub);
        @(posedge mclk_i);
        reg_sel_o <= 1'b1;
        reg_sub_o <= sub;
        @(posedge mclk_i);
        reg_sel_o <= 1'b0;
        reg_sub_o <= ~sub; // not sampled now, so show garbage
    endtask : sel

    // one byte; a missing valid pulse turns the byte unknown so any compare fails
    task automatic rd(output logic [7:0] d);
        @(posedge mclk_i);
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
    endtask : rd

    // single-byte write at sub
    task automatic wr(input logic [7:0] sub, input logic [7:0] data);
        sel(sub);
        @(posedge mclk_i);
        reg_wr_o <= 1'b1;
        reg_wdata_o <= data;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~data;
    endtask : wr

    // dummy read at x low without increment refreshes the output registers
    task automatic dummy();
        logic [7:0] d;
        sel(8'h28);
        rd(d);
    endtask : dummy

    // six-byte burst from y low, wrapping past z high to end on x high
    task automatic burst6(output logic [7:0] b [6]);
        sel(8'haa);
        for (int k = 0; k < 6; k++) begin
            rd(b[k]);
        end
    endtask : burst6
endmodule : tasf_host

`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the three axis sample buffer
// assumes tasf_pkg and tasf_buffer are compiled first
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import tasf_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic mclk_i;
    logic arst_n_i;
    logic sample_valid_i;
    tasf_sample_t sample_x_i, sample_y_i, sample_z_i;
    logic reg_sel_i, reg_rd_i, reg_wr_i, reg_rvalid_o, ready_irq2_pin_o;
    logic [7:0] reg_sub_i, reg_wdata_i, reg_rdata_o;
    int error_cnt, cmp_count, cycles;
    logic [7:0] d;
    logic [7:0] b [6];

    tasf_buffer tasf_buffer_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sample_valid_i(sample_valid_i),
        .sample_x_i(sample_x_i), .sample_y_i(sample_y_i), .sample_z_i(sample_z_i), .reg_sel_i(reg_sel_i),
        .reg_sub_i(reg_sub_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .ready_irq2_pin_o(ready_irq2_pin_o));
    tasf_host tasf_host_i (.mclk_i(mclk_i), .reg_sel_o(reg_sel_i), .reg_sub_o(reg_sub_i),
        .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
        .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

    // 125 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // sample i of channel ch (1 x, 2 y, 3 z): channel in the high byte, index in the low
    function automatic tasf_sample_t smp(input int i, input int ch);
        return {4'(ch), 4'h0, 8'(i)};
    endfunction : smp

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic push(input int i);
        @(posedge mclk_i);
        sample_valid_i <= 1'b1;
        sample_x_i <= smp(i, 1);
        sample_y_i <= smp(i, 2);
        sample_z_i <= smp(i, 3);
        @(posedge mclk_i);
        sample_valid_i <= 1'b0;
    endtask : push

    task automatic rdreg(input string name, input logic [7:0] sub, input logic [7:0] exp);
        tasf_host_i.sel(sub);
        tasf_host_i.rd(d);
        chk(name, d, exp);
    endtask : rdreg

    // irq is combinational from registered state; let the edge settle first
    task automatic irq_chk(input logic exp);
        #1;
        chk("irq", {7'h0, ready_irq2_pin_o}, {7'h0, exp});
    endtask : irq_chk

    // burst bytes come y, z, x: entry i must appear whole
    task automatic drain_chk(input int i);
        tasf_sample_t e;
        tasf_host_i.burst6(b);
        for (int k = 0; k < 6; k++) begin
            e = smp(i, (k < 2) ? 2 : (k < 4) ? 3 : 1);
            chk("burst", b[k], k[0] ? e[15:8] : e[7:0]);
        end
    endtask : drain_chk

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // hang guard, far above the roughly 800 cycles the sequence needs
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        arst_n_i = 1'b0;
        sample_valid_i = 1'b0;
        sample_x_i = '0;
        sample_y_i = '0;
        sample_z_i = '0;
        error_cnt = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (16) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        // reset state, and an unmapped place reads zero
        rdreg("ctrl", 8'h30, 8'h00);
        rdreg("pincfg", 8'h32, 8'h00);
        rdreg("src", 8'h31, 8'h20);
        rdreg("unmapped", 8'h10, 8'h00);
        // bypass: newest sample overwrites, burst wraps z high to x low
        push(5);
        push(6);
        tasf_host_i.sel(8'ha8);
        for (int k = 0; k < 7; k++) begin
            tasf_host_i.rd(d);
            chk("live", d, k[0] ? 8'(smp(6, (k % 6) / 2 + 1) >> 8) : 8'(smp(6, (k % 6) / 2 + 1)));
        end
        rdreg("src", 8'h31, 8'h20);
        tasf_host_i.wr(8'h32, 8'h01);
        irq_chk(1'b1);
        // fifo, watermark 4
        tasf_host_i.wr(8'h32, 8'h04);
        tasf_host_i.wr(8'h30, 8'h24);
        for (int i = 0; i < 3; i++) push(i);
        irq_chk(1'b0);
        push(3);
        irq_chk(1'b1);
        for (int i = 4; i < 33; i++) push(i);
        rdreg("src", 8'h31, 8'hc0);
        tasf_host_i.wr(8'h32, 8'h02);
        irq_chk(1'b1);
        tasf_host_i.dummy();
        for (int i = 0; i < 32; i++) drain_chk(i);
        rdreg("src", 8'h31, 8'h20);
        // full fifo restarts only through bypass
        for (int i = 0; i < 32; i++) push(i);
        tasf_host_i.wr(8'h30, 8'h04);
        tasf_host_i.wr(8'h30, 8'h24);
        push(40);
        rdreg("src", 8'h31, 8'h01);
        // stream: two oldest dropped after 34 samples
        tasf_host_i.wr(8'h30, 8'h00);
        tasf_host_i.wr(8'h30, 8'h40);
        for (int i = 0; i < 34; i++) push(i);
        rdreg("src", 8'h31, 8'hc0);
        tasf_host_i.dummy();
        drain_chk(2);
        // trigger buffers like stream; an unnamed code acts as bypass
        tasf_host_i.wr(8'h30, 8'h00);
        tasf_host_i.wr(8'h30, 8'h60);
        push(7);
        rdreg("src", 8'h31, 8'h81);
        tasf_host_i.wr(8'h30, 8'ha0);
        push(8);
        rdreg("src", 8'h31, 8'h20);
        summarize();
    end
endmodule : testbench

`default_nettype wire
